//--- rtmux_pkg.sv
// Functional notes
// R1: First quadrature bit of each burst flagged invalid.
// R2: Bit strobe low one sample period per bit.
// R3: Sample tick external or internal per select bit.
// R4: Receiver logic advances on sample tick rising.
// R5: Symbol results advance on tick before symbol fall.
// R6: Burst flag rises one bit before first strobe.
// R7: Burst flag falls after last strobe rise.
// R8: Probe bus shows one of sixteen values.
// R9: Probe bus tristate, governed by enable input.
// R10: Codes 6-8 show sums and magnitude bits 9-2.
// R11: Codes D, E show dot and cross bits 16-9.
// R12: Values two's complement except magnitudes unsigned.
// R13: Receiver disable clears probe select to zero.
// R14: Above 20 MHz trust only per-symbol values.
// R15: Transmit probe shows I, Q or spreading code.
// R16: Transmit probe follows low address lines always.
// R17: Transmit probe valid only below 20 MHz.
// R18: Enable high floats bus, low drives value.
// R19: Master reset clears probe select and paths.
// R20: Remaining codes map to inputs, NCO, downconverter.
// R21: All timing outputs synchronous to sample clock.
package rtmux_pkg;

    // Register offset of the probe select and its field layout.
    localparam logic [6:0] RTMUX_PROBE_SEL_ADDR  = 7'h38;
    localparam int         RTMUX_SEL_LSB         = 0;
    localparam int         RTMUX_SEL_W           = 4;
    localparam logic [3:0] RTMUX_SEL_RESET       = 4'h0;

    // Probe select codes.
    localparam logic [3:0] RTMUX_SEL_MF_IN       = 4'h0;
    localparam logic [3:0] RTMUX_SEL_PEAK_MAG    = 4'h1;
    localparam logic [3:0] RTMUX_SEL_COS         = 4'h2;
    localparam logic [3:0] RTMUX_SEL_SIN         = 4'h3;
    localparam logic [3:0] RTMUX_SEL_DC_I        = 4'h4;
    localparam logic [3:0] RTMUX_SEL_DC_Q        = 4'h5;
    localparam logic [3:0] RTMUX_SEL_MF_I        = 4'h6;
    localparam logic [3:0] RTMUX_SEL_MF_Q        = 4'h7;
    localparam logic [3:0] RTMUX_SEL_MF_MAG      = 4'h8;
    localparam logic [3:0] RTMUX_SEL_VP_I        = 4'h9;
    localparam logic [3:0] RTMUX_SEL_VP_Q        = 4'ha;
    localparam logic [3:0] RTMUX_SEL_PK_I        = 4'hb;
    localparam logic [3:0] RTMUX_SEL_PK_Q        = 4'hc;
    localparam logic [3:0] RTMUX_SEL_DOT         = 4'hd;
    localparam logic [3:0] RTMUX_SEL_CROSS       = 4'he;
    localparam logic [3:0] RTMUX_SEL_LOOP        = 4'hf;

    // Transmit probe codes on the low address lines.
    localparam logic [1:0] RTMUX_TX_SEL_I        = 2'h0;
    localparam logic [1:0] RTMUX_TX_SEL_Q        = 2'h1;
    localparam logic [1:0] RTMUX_TX_SEL_CODE     = 2'h2;

    // Internal sample divider reset value.
    localparam logic [5:0] RTMUX_DIV_RESET       = 6'h00;

    // Internal probe sources from the receiver datapath.
    typedef struct packed {
        logic [2:0]  mf_quad_input;
        logic [2:0]  mf_inphase_input;
        logic [9:0]  peak_magnitude;
        logic [7:0]  nco_cos;
        logic [7:0]  nco_sin;
        logic [16:0] downconv_inphase_out;
        logic [16:0] downconv_quad_out;
        logic [9:0]  mf_inphase_sum;
        logic [9:0]  mf_quad_sum;
        logic [9:0]  mf_magnitude;
        logic [7:0]  peak_inphase_sum;
        logic [7:0]  peak_quad_sum;
        logic [16:0] dot_product;
        logic [16:0] cross_product;
        logic [7:0]  loopback_probe;
    } rtmux_probe_src_type;

    // Receiver symbol results entering the output stage.
    typedef struct packed {
        logic symbol_done;
        logic bit_i;
        logic bit_q;
        logic burst_start;
        logic burst_last;
    } rtmux_sym_type;

    // Burst timing state machine, Gray coded.
    typedef enum logic [1:0] {
        RTMUX_IDLE  = 2'b00,
        RTMUX_ARMED = 2'b01,
        RTMUX_BURST = 2'b11,
        RTMUX_LAST  = 2'b10
    } rtmux_state_type;

    // Whole state of the block.
    typedef struct packed {
        rtmux_state_type state;
        logic [5:0]      div_cnt;
        logic            tick;
        logic            ext_prev;
        logic            sym_tick;
        logic            strobe_n;
        logic            active;
        logic            first_bit;
        logic            bit_i;
        logic            bit_q;
        logic            bit_serial;
        logic            q_valid;
        logic [3:0]      sel;
        logic [7:0]      probe;
        logic            probe_oe;
        logic            tx_probe;
    } rtmux_state_vec_type;

endpackage : rtmux_pkg

//--- rtmux_timing_probe.sv
`timescale 1ns/1ps
`default_nettype none
// Receiver output timing strobes and the test-point multiplexers.
module rtmux_timing_probe (
    // Clock and reset.
    input  wire logic                          i_clk,
    input  wire logic                          i_arst_n,
    // Host write port.
    input  wire logic                          i_host_cs_n,
    input  wire logic                          i_host_wr_n,
    input  wire logic [6:0]                    i_host_addr,
    input  wire logic [7:0]                    i_host_data,
    input  wire logic                          i_rx_enable,
    // Sample clock control.
    input  wire logic                          i_manual_sample_sel,
    input  wire logic [5:0]                    i_sample_div,
    input  wire logic                          i_ext_sample,
    // Receiver datapath.
    input  wire rtmux_pkg::rtmux_sym_type      i_sym,
    input  wire rtmux_pkg::rtmux_probe_src_type i_src,
    // Transmit probe sources.
    input  wire logic                          i_unspread_inphase_symbol,
    input  wire logic                          i_unspread_quad_symbol,
    input  wire logic                          i_spreading_code_bit,
    // Probe output enable, active low.
    input  wire logic                          i_probe_output_enable_n,
    // Receiver timing outputs.
    output var  logic                          o_rx_bit_strobe_n,
    output var  logic                          o_rx_sample_tick,
    output var  logic                          o_rx_symbol_tick,
    output var  logic                          o_rx_burst_active,
    output var  logic                          o_rx_serial_bit_out,
    output var  logic                          o_rx_inphase_bit_out,
    output var  logic                          o_rx_quad_bit_out,
    output var  logic                          o_rx_quad_bit_valid,
    // Probe outputs.
    output var  logic [7:0]                    o_rx_probe_bus,
    output var  logic                          o_probe_drive_enable,
    output var  logic                          o_tx_probe_out
);
    import rtmux_pkg::*;

    // The whole state is one record, so reset and update cover every field.
    rtmux_state_vec_type s_reg;   // Registered state.
    rtmux_state_vec_type s_next;  // Next state.
    logic                rise;    // Sample tick rising this cycle.

    // The sample tick is the only rate below the clock. It is carried as a
    // one-cycle rise pulse, so every receiver update happens on a plain
    // clock edge and no derived clock exists anywhere in the block.
    // Next-state logic for all block state.
    always_comb begin
        s_next = s_reg;
        rise   = 1'b0;
        // Sample tick from the external source or the divider. R3
        if (i_manual_sample_sel) begin
            // The external level is registered once, so the pin trails the
            // input by one clock; the rise is found against the previous
            // level, so a level held high gives a single rise.
            s_next.ext_prev = i_ext_sample;
            s_next.tick     = i_ext_sample;
            rise            = i_ext_sample & ~s_reg.ext_prev;
        end else begin
            // The counter wraps at the programmed value; a value written
            // below the count takes effect at once, with no long wait.
            // Rate is clock divided by n+1.
            if (s_reg.div_cnt >= i_sample_div) begin
                s_next.div_cnt = RTMUX_DIV_RESET;
                rise           = 1'b1;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 6'h01;
            end
            // The tick is high for the one clock after each wrap.
            s_next.tick = (s_next.div_cnt == RTMUX_DIV_RESET); // R3 R21
        end
        // Nothing in this branch moves unless the sample tick rises, so strobe,
        // symbol tick and data bits all stand for a whole sample period
        // and change together.
        // Strobe is high except during one sample period per bit. R2
        if (rise) begin
            s_next.strobe_n = 1'b1;
            s_next.sym_tick = 1'b0;
            // Results advance only on a sample tick rising edge. R4 R5
            if (i_sym.symbol_done) begin
                s_next.sym_tick   = 1'b1; // Falls at the next tick. R5
                s_next.bit_i      = i_sym.bit_i;
                s_next.bit_q      = i_sym.bit_q;
                s_next.bit_serial = i_sym.bit_i;
            end
            case (s_reg.state)
                // Preamble seen: raise flag one bit ahead of strobe. R6
                RTMUX_IDLE: begin
                    // The flag goes up a bit period before the first strobe,
                    // giving user logic time to arm its capture.
                    if (i_sym.burst_start) begin
                        s_next.active    = 1'b1; // R6
                        s_next.first_bit = 1'b1;
                        s_next.state     = RTMUX_ARMED;
                    end
                end
                // First bit of the burst arrives.
                RTMUX_ARMED: begin
                    // The quadrature bit of this first symbol is marked
                    // invalid, so that user logic can drop it.
                    if (i_sym.symbol_done) begin
                        s_next.strobe_n  = 1'b0; // R2
                        s_next.q_valid   = 1'b0; // R1
                        s_next.first_bit = 1'b0;
                        s_next.state     = i_sym.burst_last ? RTMUX_LAST : RTMUX_BURST;
                    end
                end
                // Following bits; quadrature bit now valid.
                RTMUX_BURST: begin
                    // Later symbols give a strobe and a valid quadrature bit;
                    // the last one moves on so the flag can drop.
                    if (i_sym.symbol_done) begin
                        s_next.strobe_n = 1'b0; // R2
                        s_next.q_valid  = 1'b1; // R1
                        if (i_sym.burst_last) begin
                            s_next.state = RTMUX_LAST;
                        end
                    end
                end
                // Last strobe rises now: drop the flag. R7
                RTMUX_LAST: begin
                    // The strobe returns high at this same rise, so flag and
                    // strobe change on one edge.
                    s_next.active = 1'b0; // R7
                    s_next.state  = RTMUX_IDLE;
                end
                default: begin
                    // Unused code: return to idle rather than lock up.
                    s_next.state = RTMUX_IDLE;
                end
            endcase
        end
        // A write is taken on every clock at which chip select, write and
        // address all stand; a held write stores the same value again.
        // Only the low nibble is kept; the upper data bits are ignored.
        // Host writes reach the select only with chip select low. R8
        if (!i_host_cs_n && !i_host_wr_n && i_host_addr == RTMUX_PROBE_SEL_ADDR) begin
            s_next.sel = i_host_data[RTMUX_SEL_LSB +: RTMUX_SEL_W];
        end
        // Disable is tested after the write, so it wins over a write in
        // the same cycle and the select reads zero while it lasts.
        // Receiver disable clears the select. R13
        if (!i_rx_enable) begin
            s_next.sel = RTMUX_SEL_RESET; // R13
        end
        // The bus is registered, so a new select shows one clock after
        // the write edge and a new source value one clock after it comes.
        // Sources pass unchanged, keeping the sign format of each source.
        // Probe multiplexer; magnitudes unsigned, others signed. R8 R12 R20
        case (s_reg.sel)
            // Code 0 packs both three-bit inputs; the top two bits read zero.
            RTMUX_SEL_MF_IN:    s_next.probe = {2'b00, i_src.mf_quad_input,
                                                i_src.mf_inphase_input};
            RTMUX_SEL_PEAK_MAG: s_next.probe = i_src.peak_magnitude[9:2];
            RTMUX_SEL_COS:      s_next.probe = i_src.nco_cos;
            RTMUX_SEL_SIN:      s_next.probe = i_src.nco_sin;
            RTMUX_SEL_DC_I:     s_next.probe = i_src.downconv_inphase_out[16:9];
            RTMUX_SEL_DC_Q:     s_next.probe = i_src.downconv_quad_out[16:9];
            // Codes 6-8: matched filter sums and magnitude drop their two low bits; codes 9 and A keep the sums' bits 7-0.
            RTMUX_SEL_MF_I:     s_next.probe = i_src.mf_inphase_sum[9:2]; // R10
            RTMUX_SEL_MF_Q:     s_next.probe = i_src.mf_quad_sum[9:2]; // R10
            RTMUX_SEL_MF_MAG:   s_next.probe = i_src.mf_magnitude[9:2]; // R10
            RTMUX_SEL_VP_I:     s_next.probe = i_src.mf_inphase_sum[7:0];
            RTMUX_SEL_VP_Q:     s_next.probe = i_src.mf_quad_sum[7:0];
            RTMUX_SEL_PK_I:     s_next.probe = i_src.peak_inphase_sum;
            RTMUX_SEL_PK_Q:     s_next.probe = i_src.peak_quad_sum;
            // Demodulator products keep their top eight bits.
            RTMUX_SEL_DOT:      s_next.probe = i_src.dot_product[16:9]; // R11
            RTMUX_SEL_CROSS:    s_next.probe = i_src.cross_product[16:9]; // R11
            default:            s_next.probe = i_src.loopback_probe;
        endcase
        // The drive enable is registered like the bus, so the pad driver
        // takes both its value and its enable from flip-flops.
        // Drivers follow the active-low enable. R9 R18
        s_next.probe_oe = ~i_probe_output_enable_n;
        // The transmit probe decodes the low address lines on every clock,
        // whether or not the host is writing; code 3 has no source and
        // gives a steady zero.
        // Transmit probe follows address bits 1-0 always. R15 R16
        case (i_host_addr[1:0])
            RTMUX_TX_SEL_I:    s_next.tx_probe = i_unspread_inphase_symbol;
            RTMUX_TX_SEL_Q:    s_next.tx_probe = i_unspread_quad_symbol;
            RTMUX_TX_SEL_CODE: s_next.tx_probe = i_spreading_code_bit;
            default:           s_next.tx_probe = 1'b0;
        endcase
    end

    // The reset branch loads constants only; the strobe idles high, so it
    // is set apart from the all-zero clear.
    // State register; master reset clears everything but the strobe, which it sets high. R19
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_reg          <= '0;
            s_reg.strobe_n <= 1'b1;
            s_reg.state    <= RTMUX_IDLE;
            s_reg.sel      <= RTMUX_SEL_RESET; // R19
        end else begin
            s_reg <= s_next;
        end
    end

    // No logic stands between a register and a pin, so every output is
    // free of glitches.
    // Outputs come straight from the state register.
    assign o_rx_bit_strobe_n    = s_reg.strobe_n;
    assign o_rx_sample_tick     = s_reg.tick;
    assign o_rx_symbol_tick     = s_reg.sym_tick;
    assign o_rx_burst_active    = s_reg.active;
    assign o_rx_serial_bit_out  = s_reg.bit_serial;
    assign o_rx_inphase_bit_out = s_reg.bit_i;
    assign o_rx_quad_bit_out    = s_reg.bit_q;
    assign o_rx_quad_bit_valid  = s_reg.q_valid;
    assign o_rx_probe_bus       = s_reg.probe;
    assign o_probe_drive_enable = s_reg.probe_oe;
    assign o_tx_probe_out       = s_reg.tx_probe;

endmodule // rtmux_timing_probe
`default_nettype wire

//--- rtmux_timing_probe_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the strobe, sample tick and burst flag and both probe paths at the ports of the block.
module rtmux_timing_probe_monitor (
    input wire logic                           i_clk,
    input wire logic                           i_arst_n,
    input wire logic                           i_rx_enable,
    input wire logic [6:0]                     i_host_addr,
    input wire rtmux_pkg::rtmux_probe_src_type i_src,
    input wire logic                           i_unspread_inphase_symbol,
    input wire logic                           i_unspread_quad_symbol,
    input wire logic                           i_spreading_code_bit,
    input wire logic                           i_probe_output_enable_n,
    input wire logic                           o_rx_bit_strobe_n,
    input wire logic                           o_rx_sample_tick,
    input wire logic                           o_rx_burst_active,
    input wire logic [7:0]                     o_rx_probe_bus,
    input wire logic                           o_probe_drive_enable,
    input wire logic                           o_tx_probe_out
);
    import rtmux_pkg::*;
    // All checks live in the sample clock domain.
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Two cycles of receiver disable clear the select before the bus follows.
    sequence s_rx_off;
        !i_rx_enable ##1 !i_rx_enable;
    endsequence
    property p_sel_clear;
        s_rx_off |=> o_rx_probe_bus[5:0] == $past({i_src.mf_quad_input, i_src.mf_inphase_input});
    endproperty
    property p_drv;
        $changed(i_probe_output_enable_n) |=> o_probe_drive_enable == !$past(i_probe_output_enable_n);
    endproperty
    property p_tx0;
        i_host_addr[1:0] == 2'h0 |=> o_tx_probe_out == $past(i_unspread_inphase_symbol);
    endproperty
    property p_tx1;
        i_host_addr[1:0] == 2'h1 |=> o_tx_probe_out == $past(i_unspread_quad_symbol);
    endproperty
    property p_tx2;
        i_host_addr[1:0] == 2'h2 |=> o_tx_probe_out == $past(i_spreading_code_bit);
    endproperty
    property p_strobe_burst;
        !o_rx_bit_strobe_n |-> o_rx_burst_active;
    endproperty
    property p_strobe_tick;
        $changed(o_rx_bit_strobe_n) |-> $rose(o_rx_sample_tick);
    endproperty
    property p_fall;
        $fell(o_rx_burst_active) |-> o_rx_bit_strobe_n && $rose(o_rx_sample_tick);
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("probe select not cleared");
    a_drv: assert property (p_drv) else $error("probe drive enable late");
    a_tx0: assert property (p_tx0) else $error("tx probe code 0 wrong");
    a_tx1: assert property (p_tx1) else $error("tx probe code 1 wrong");
    a_tx2: assert property (p_tx2) else $error("tx probe code 2 wrong");
    a_strobe_burst: assert property (p_strobe_burst) else $error("strobe outside burst");
    a_strobe_tick: assert property (p_strobe_tick) else $error("strobe off tick");
    a_fall: assert property (p_fall) else $error("burst flag fell early");
endmodule // rtmux_timing_probe_monitor
bind rtmux_timing_probe rtmux_timing_probe_monitor i_mon (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_rx_enable(i_rx_enable), .i_host_addr(i_host_addr), .i_src(i_src),
    .i_unspread_inphase_symbol(i_unspread_inphase_symbol),
    .i_unspread_quad_symbol(i_unspread_quad_symbol), .i_spreading_code_bit(i_spreading_code_bit),
    .i_probe_output_enable_n(i_probe_output_enable_n), .o_rx_bit_strobe_n(o_rx_bit_strobe_n),
    .o_rx_sample_tick(o_rx_sample_tick), .o_rx_burst_active(o_rx_burst_active),
    .o_rx_probe_bus(o_rx_probe_bus), .o_probe_drive_enable(o_probe_drive_enable),
    .o_tx_probe_out(o_tx_probe_out));
`default_nettype wire

//--- rtmux_rx_user.sv
`timescale 1ns/1ps
`default_nettype none
// User receive logic: takes one bit per strobe fall inside a burst.
module rtmux_rx_user (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_strobe_n,
    input  wire logic       i_q_valid,
    output logic [7:0]      o_bit_count,
    output logic            o_first_q_valid
);
    logic prev_n;
    // Count strobes; the first quad bit's validity is kept so it can be discarded.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_n <= 1'b1;
            o_bit_count <= 8'h00;
            o_first_q_valid <= 1'b1;
        end else begin
            prev_n <= i_strobe_n;
            if (prev_n && !i_strobe_n) begin
                o_bit_count <= o_bit_count + 8'h01;
                if (o_bit_count == 8'h00) o_first_q_valid <= i_q_valid;
            end
        end
    end
endmodule // rtmux_rx_user
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the timing strobes and probe multiplexers.
module tb_top;
    import rtmux_pkg::*;
    logic clk = 0, arst_n = 0, cs_n = 1, wr_n = 1, en = 1, msel = 0, ext = 0, oe_n = 1;
    logic [6:0] addr = 7'h00;
    logic [7:0] data = 8'h00, n, cnt;
    logic [5:0] div = 6'h03;
    logic [2:0] txs = 3'h0;
    logic [1:0] bv;
    logic [159:0] r;
    rtmux_sym_type sym = '0;
    rtmux_probe_src_type src = '0;
    logic strobe_n, tick, symt, act, sb, ib, qb, qv, drv, txo, fq;
    logic [7:0] probe;
    int mismatches = 0, cmp_count = 0;
    rtmux_timing_probe i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_host_cs_n(cs_n),
        .i_host_wr_n(wr_n), .i_host_addr(addr), .i_host_data(data), .i_rx_enable(en),
        .i_manual_sample_sel(msel), .i_sample_div(div), .i_ext_sample(ext), .i_sym(sym),
        .i_src(src), .i_unspread_inphase_symbol(txs[0]), .i_unspread_quad_symbol(txs[1]),
        .i_spreading_code_bit(txs[2]), .i_probe_output_enable_n(oe_n),
        .o_rx_bit_strobe_n(strobe_n), .o_rx_sample_tick(tick), .o_rx_symbol_tick(symt),
        .o_rx_burst_active(act), .o_rx_serial_bit_out(sb), .o_rx_inphase_bit_out(ib),
        .o_rx_quad_bit_out(qb), .o_rx_quad_bit_valid(qv), .o_rx_probe_bus(probe),
        .o_probe_drive_enable(drv), .o_tx_probe_out(txo));
    rtmux_rx_user i_user (.i_clk(clk), .i_arst_n(arst_n), .i_strobe_n(strobe_n),
        .i_q_valid(qv), .o_bit_count(cnt), .o_first_q_valid(fq));
    // 100 MHz sample clock.
    initial begin
        forever #5 clk = ~clk;
    end
    // Compares one value and counts the result.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic conclude;
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One host write cycle; c is the chip select level.
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic c);
        @(posedge clk);
        cs_n <= c; wr_n <= 1'b0; addr <= a; data <= d;
        @(posedge clk);
        cs_n <= 1'b1; wr_n <= 1'b1;
    endtask
    // Holds one symbol word for a whole sample period.
    task automatic sy(input logic [4:0] v);
        sym <= v;
        repeat (4) @(posedge clk);
    endtask
    // Expected probe bus value for a select code.
    function automatic logic [7:0] pexp(input logic [3:0] s);
        case (s)
            4'h0: return {2'h0, src.mf_quad_input, src.mf_inphase_input};
            4'h1: return src.peak_magnitude[9:2];
            4'h2: return src.nco_cos;
            4'h3: return src.nco_sin;
            4'h4: return src.downconv_inphase_out[16:9];
            4'h5: return src.downconv_quad_out[16:9];
            4'h6: return src.mf_inphase_sum[9:2];
            4'h7: return src.mf_quad_sum[9:2];
            4'h8: return src.mf_magnitude[9:2];
            4'h9: return src.mf_inphase_sum[7:0];
            4'ha: return src.mf_quad_sum[7:0];
            4'hb: return src.peak_inphase_sum;
            4'hc: return src.peak_quad_sum;
            4'hd: return src.dot_product[16:9];
            4'he: return src.cross_product[16:9];
            default: return src.loopback_probe;
        endcase
    endfunction
    // Watchdog against a hang.
    initial begin
        #200us;
        mismatches++;
        conclude();
    end
    initial begin
        void'($urandom(82));
        repeat (8) @(posedge clk);
        chk("strobe_n in reset", 8'h01, {7'h0, strobe_n});
        chk("probe in reset", 8'h00, probe);
        arst_n <= 1'b1;
        n = 8'h00;
        repeat (40) begin
            @(posedge clk); #1;
            if (tick === 1'b1) n++;
        end
        chk("tick rate", 8'h0a, n);
        // Sources hold still for four clocks before each probe read.
        oe_n <= 1'b0;
        for (int s = 0; s < 16; s++) begin
            r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
            src <= r[$bits(src)-1:0];
            wr(7'h38, {4'($urandom()), 4'(s)}, 1'b0);
            repeat (2) @(posedge clk); #1;
            chk("probe", pexp(4'(s)) & ((s == 0) ? 8'h3f : 8'hff), probe & ((s == 0) ? 8'h3f : 8'hff));
            chk("drive", 8'h01, {7'h0, drv});
        end
        wr(7'h38, 8'h00, 1'b1);
        wr(7'h39, 8'h00, 1'b0);
        oe_n <= 1'b1;
        repeat (2) @(posedge clk); #1;
        chk("refused write", src.loopback_probe, probe);
        chk("drive off", 8'h00, {7'h0, drv});
        en <= 1'b0;
        repeat (3) @(posedge clk);
        en <= 1'b1;
        @(posedge clk); #1;
        chk("disable clears", pexp(4'h0) & 8'h3f, probe & 8'h3f);
        // Transmit sources hold for two clocks before the pin is read.
        for (int c = 0; c < 4; c++) begin
            addr <= {5'($urandom()), 2'(c)};
            txs <= 3'($urandom());
            repeat (2) @(posedge clk); #1;
            chk("tx probe", (c == 3) ? 8'h00 : {7'h0, txs[c % 3]}, {7'h0, txo});
        end
        // A second reset in mid-run must clear a written select again.
        wr(7'h38, 8'h0f, 1'b0);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk); #1;
        chk("reset clears select", pexp(4'h0), probe);
        chk("strobe_n after reset", 8'h01, {7'h0, strobe_n});
        msel <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            ext <= 1'($urandom());
            @(posedge clk); #1;
            chk("ext tick", {7'h0, ext}, {7'h0, tick});
        end
        msel <= 1'b0;
        sy(5'b00010);
        #1 chk("flag before bit", 8'h03, {6'h0, act, strobe_n});
        // Each bit symbol is followed by an idle sample period, as symbols span many.
        for (int k = 0; k < 5; k++) begin
            bv = 2'($urandom());
            sy({1'b1, bv, 1'b0, (k == 4)});
            #1 chk("bits", {5'h0, bv[1], bv[1], bv[0]}, {5'h0, sb, ib, qb});
            chk("sym tick", 8'h01, {7'h0, symt});
            chk("strobe low", 8'h00, {7'h0, strobe_n});
            sy(5'b00000);
        end
        repeat (4) sy(5'b00000);
        chk("flag after burst", 8'h00, {7'h0, act});
        chk("sym tick idle", 8'h00, {7'h0, symt});
        chk("bit count", 8'h05, cnt);
        chk("first q valid", 8'h00, {7'h0, fq});
        conclude();
    end
endmodule // tb_top
`default_nettype wire
